// ### shared/instr_slice_pkg.sv
// Package for the move and shift instruction slice: opcodes, layouts, map.
package instr_slice_pkg;

    // Operation codes presented on the decoder's operation port.
    typedef enum logic [3:0] {
        OP_NONE,
        OP_LSL,
        OP_LSR,
        OP_FMOVE,
        OP_ILOAD,
        OP_BANK_LIT,
        OP_PAGE_LIT,
        OP_ACC_LIT,
        OP_ACC_STORE
    } op_code_t;

    // Indirect pointer update modes.
    localparam logic [1:0] MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;

    // One instruction as issued to the slice.
    typedef struct packed {
        op_code_t   op;
        logic [6:0] file_addr;
        logic       dest;
        logic       ptr_sel;
        logic       rel_form;
        logic [1:0] mode;
        logic [7:0] literal;
    } instr_t;

    // Register bus offsets (byte addresses).
    localparam logic [7:0] ADDR_INSTR  = 8'h00;
    localparam logic [7:0] ADDR_ACC    = 8'h04;
    localparam logic [7:0] ADDR_FLAGS  = 8'h08;
    localparam logic [7:0] ADDR_BANK   = 8'h0c;
    localparam logic [7:0] ADDR_PAGE   = 8'h10;
    localparam logic [7:0] ADDR_PTR0   = 8'h14;
    localparam logic [7:0] ADDR_PTR1   = 8'h18;
    localparam logic [7:0] ADDR_MEMWIN = 8'h1c;

    // Instruction word field positions and flag register bit positions.
    localparam int INSTR_OP_LSB    = 0;
    localparam int INSTR_FILE_LSB  = 4;
    localparam int INSTR_DEST_BIT  = 11;
    localparam int INSTR_PSEL_BIT  = 12;
    localparam int INSTR_REL_BIT   = 13;
    localparam int INSTR_MODE_LSB  = 14;
    localparam int INSTR_LIT_LSB   = 16;
    localparam int FLAG_CARRY_BIT  = 0;
    localparam int FLAG_ZERO_BIT   = 1;

    // Reset values.
    localparam logic [7:0]  RST_ACC  = 8'h00;
    localparam logic [4:0]  RST_BANK = 5'h00;
    localparam logic [6:0]  RST_PAGE = 7'h00;
    localparam logic [15:0] RST_PTR  = 16'h0000;

    // Indirect-port file addresses within each bank.
    localparam logic [6:0] IND_PORT0 = 7'h00;
    localparam logic [6:0] IND_PORT1 = 7'h01;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/instr_slice.sv
// Move and shift instruction slice with its data memory and AXI4-Lite port.
//
// Notes on behaviour
// RQ1 - Left shift sends bit 7 to carry, shifts up, and fills bit 0 with 0.
// RQ2 - Right shift sends bit 0 to carry, shifts down, and fills bit 7 with 0.
// RQ3 - Shift and move results go to the accumulator on dest 0, else to file.
// RQ4 - File move updates zero even when written back onto itself.
// RQ5 - Indirect load mode 00/01/10/11 is pre-inc, pre-dec, post-inc, post-dec.
// RQ6 - Relative form reads pointer plus signed offset and keeps the pointer.
// RQ7 - Indirect load picks pointer 0 or 1 by index and updates zero.
// RQ8 - Each 16-bit pointer wraps around on increment and decrement.
// RQ9 - Indirect ports hold nothing and access the location a pointer names.
// RQ10 - Bank literal load copies 5 bits to the bank register, flags kept.
// RQ11 - Page literal load copies 7 bits to the page latch, flags kept.
// RQ12 - Accumulator literal load takes one cycle and keeps the flags.
// RQ13 - Accumulator store writes the file register in one cycle, flags kept.
// RQ14 - Zero is set when the 8-bit result is zero and cleared otherwise.
// RQ15 - A direct address is the bank register joined to the 7-bit field.
module instr_slice
    import instr_slice_pkg::*;
#(
    parameter int MEM_AW = 12
) (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I
);

    // Architectural state.
    logic [7:0]  acc;
    logic        carry;
    logic        zero;
    logic [4:0]  bank_select_reg;
    logic [6:0]  program_counter_high_latch;
    logic [15:0] file_select_pointer [2];
    logic [7:0]  mem [2**MEM_AW];

    // Bus channel state: address and data held until both have arrived.
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // Map a 16-bit data address onto the memory array (upper bits ignored).
    function automatic logic [MEM_AW-1:0] mem_index(input logic [15:0] a);
        return a[MEM_AW-1:0];
    endfunction

    // Decode the instruction word carried in a register write.
    function automatic instr_t unpack(input logic [31:0] d);
        instr_t i;
        i.op        = op_code_t'(d[INSTR_OP_LSB +: 4]);
        i.file_addr = d[INSTR_FILE_LSB +: 7];
        i.dest      = d[INSTR_DEST_BIT];
        i.ptr_sel   = d[INSTR_PSEL_BIT];
        i.rel_form  = d[INSTR_REL_BIT];
        i.mode      = d[INSTR_MODE_LSB +: 2];
        i.literal   = d[INSTR_LIT_LSB +: 8];
        return i;
    endfunction

    // Write handshake: both channels held and response slot free.
    wire         wr_go     = aw_held && w_held && !S_AXI_BVALID_O;
    wire         wr_hit    = wr_go && (aw_addr[7:2] <= ADDR_MEMWIN[7:2]);
    wire         is_instr  = wr_go && aw_addr == ADDR_INSTR && w_strb[0];
    wire instr_t ins       = unpack(w_data);
    wire         exec      = is_instr && ins.op != OP_NONE;

    // Direct address formation from bank and file field.
    wire [15:0]  direct_addr = {4'h0, bank_select_reg, ins.file_addr}; // RQ15

    // An access to an indirect port resolves to the matching pointer.
    wire         f_ind0    = ins.file_addr == IND_PORT0; // RQ9
    wire         f_ind1    = ins.file_addr == IND_PORT1; // RQ9
    wire [15:0]  f_addr    = f_ind0 ? file_select_pointer[0]
                           : f_ind1 ? file_select_pointer[1]
                           : direct_addr; // RQ9
    wire [7:0]   f_val     = mem[mem_index(f_addr)];

    // Indirect load address and pointer update; 16-bit adds wrap by width.
    wire [15:0]  ptr       = file_select_pointer[ins.ptr_sel]; // RQ7
    wire [15:0]  ptr_inc   = ptr + 16'h0001; // RQ8
    wire [15:0]  ptr_dec   = ptr - 16'h0001; // RQ8
    wire [15:0]  rel_off   = {{10{ins.literal[5]}}, ins.literal[5:0]};
    wire [15:0]  rel_addr  = ptr + rel_off; // RQ6
    wire [15:0]  ind_addr  = ins.rel_form ? rel_addr
                           : (ins.mode == MODE_PRE_INC)  ? ptr_inc
                           : (ins.mode == MODE_PRE_DEC)  ? ptr_dec
                           : ptr; // RQ5
    wire [15:0]  ptr_after = ins.rel_form ? ptr
                           : (ins.mode == MODE_PRE_INC ||
                              ins.mode == MODE_POST_INC) ? ptr_inc
                           : ptr_dec; // RQ5
    wire [7:0]   ind_val   = mem[mem_index(ind_addr)];

    // Result selection per operation.
    logic [7:0] result;
    logic       next_carry;
    always_comb begin
        result     = f_val;
        next_carry = carry;
        case (ins.op)
            OP_LSL: begin
                result     = {f_val[6:0], 1'b0}; // RQ1
                next_carry = f_val[7]; // RQ1
            end
            OP_LSR: begin
                result     = {1'b0, f_val[7:1]}; // RQ2
                next_carry = f_val[0]; // RQ2
            end
            OP_ILOAD:    result = ind_val;
            OP_ACC_LIT:  result = ins.literal;
            OP_ACC_STORE: result = acc;
            default:     result = f_val;
        endcase
    end

    wire shift_op  = ins.op == OP_LSL || ins.op == OP_LSR;
    wire zero_op   = shift_op || ins.op == OP_FMOVE || ins.op == OP_ILOAD;
    wire to_file   = ((shift_op || ins.op == OP_FMOVE) && ins.dest)
                   || ins.op == OP_ACC_STORE; // RQ3 RQ13
    wire to_acc    = ((shift_op || ins.op == OP_FMOVE) && !ins.dest)
                   || ins.op == OP_ILOAD || ins.op == OP_ACC_LIT; // RQ3 RQ12
    wire [7:0] next_acc = to_acc ? result : acc;

    // Instruction execution: one bus write completes one instruction.
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            acc                        <= RST_ACC;
            carry                      <= 1'b0;
            zero                       <= 1'b0;
            bank_select_reg            <= RST_BANK;
            program_counter_high_latch <= RST_PAGE;
            file_select_pointer[0]     <= RST_PTR;
            file_select_pointer[1]     <= RST_PTR;
        end else if (exec) begin
            acc <= next_acc; // RQ12
            if (shift_op) begin
                carry <= next_carry; // RQ1 RQ2
            end
            if (zero_op) begin
                zero <= (result == 8'h00); // RQ4 RQ7 RQ14
            end
            if (ins.op == OP_BANK_LIT) begin
                bank_select_reg <= ins.literal[4:0]; // RQ10
            end
            if (ins.op == OP_PAGE_LIT) begin
                program_counter_high_latch <= ins.literal[6:0]; // RQ11
            end
            if (ins.op == OP_ILOAD) begin
                file_select_pointer[ins.ptr_sel] <= ptr_after; // RQ5 RQ8
            end
        end
    end

    // File memory: written by instructions or by the memory window.
    wire mem_win_wr = wr_go && aw_addr == ADDR_MEMWIN && w_strb[0];
    always_ff @(posedge CLOCK_I) begin
        if (exec && to_file) begin
            mem[mem_index(f_addr)] <= result; // RQ3 RQ9 RQ13
        end else if (mem_win_wr) begin
            mem[mem_index(file_select_pointer[0])] <= w_data[7:0];
        end
    end

    // Write channels: each is taken on its own and held for the pair.
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= 8'h00;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O;
            S_AXI_WREADY_O  <= !w_held && !S_AXI_WREADY_O;
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end
            if (wr_go) begin
                aw_held         <= 1'b0;
                w_held          <= 1'b0;
                S_AXI_BVALID_O  <= 1'b1;
                S_AXI_BRESP_O   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // Read decode; the memory window reads through pointer 0.
    logic [31:0] rd_word;
    always_comb begin
        case (S_AXI_ARADDR_I)
            ADDR_INSTR: rd_word = 32'h0000_0000;
            ADDR_ACC:   rd_word = {24'h000000, acc};
            ADDR_FLAGS: rd_word = {30'h0, zero, carry};
            ADDR_BANK:  rd_word = {27'h0, bank_select_reg};
            ADDR_PAGE:  rd_word = {25'h0, program_counter_high_latch};
            ADDR_PTR0:  rd_word = {16'h0000, file_select_pointer[0]};
            ADDR_PTR1:  rd_word = {16'h0000, file_select_pointer[1]};
            ADDR_MEMWIN: rd_word = {24'h000000,
                                    mem[mem_index(file_select_pointer[0])]};
            default:    rd_word = 32'h0000_0000;
        endcase
    end
    wire rd_hit = S_AXI_ARADDR_I[7:2] <= ADDR_MEMWIN[7:2]
               && S_AXI_ARADDR_I[1:0] == 2'h0;

    // Read channel: address taken, data answered on the next cycle.
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !S_AXI_ARREADY_O
                             && S_AXI_ARVALID_I;
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O  <= rd_word;
                S_AXI_RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // Checks that tie state changes to the executed instruction.
    sequence lit_exec_s;
        exec && ins.op == OP_ACC_LIT;
    endsequence

    // Sampled-value functions stand in for property-local variables, which
    // some tools do not accept.
    property acc_lit_p;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        lit_exec_s |=> acc == $past(ins.literal)
            && $stable(carry) && $stable(zero);
    endproperty
    acc_lit_load_a: assert property (acc_lit_p) // RQ12
        else $error("Literal load did not reach accumulator.");

    left_shift_a: assert property ( // RQ1
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_LSL && !ins.dest
        |=> carry == $past(f_val[7])
            && acc == {$past(f_val[6:0]), 1'b0})
        else $error("Left shift result wrong.");

    right_shift_a: assert property ( // RQ2
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_LSR && !ins.dest
        |=> carry == $past(f_val[0])
            && acc == {1'b0, $past(f_val[7:1])})
        else $error("Right shift result wrong.");

    dest_file_keep_a: assert property ( // RQ3
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && shift_op && ins.dest |=> $stable(acc))
        else $error("Accumulator changed on file destination.");

    move_zero_a: assert property ( // RQ4
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_FMOVE |=> zero == ($past(f_val) == 8'h00))
        else $error("Zero flag wrong after file move.");

    ptr_post_inc_a: assert property ( // RQ5
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_ILOAD && !ins.rel_form
        && ins.mode == MODE_POST_INC && !ins.ptr_sel
        |=> file_select_pointer[0]
            == $past(file_select_pointer[0]) + 16'h0001)
        else $error("Pointer not incremented.");

    rel_keep_ptr_a: assert property ( // RQ6
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_ILOAD && ins.rel_form
        |=> $stable(file_select_pointer[0])
            && $stable(file_select_pointer[1]))
        else $error("Relative load moved a pointer.");

    bank_flags_a: assert property ( // RQ10
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_BANK_LIT |=> $stable(zero) && $stable(carry)
        && bank_select_reg == $past(ins.literal[4:0]))
        else $error("Bank load wrong or flags changed.");

    page_latch_a: assert property ( // RQ11
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        exec && ins.op == OP_PAGE_LIT |=> $stable(zero)
        && program_counter_high_latch == $past(ins.literal[6:0]))
        else $error("Page latch load wrong.");

endmodule

// ### tb/tb_instr_slice.sv
// Self-checking testbench for the move and shift instruction slice.
module tb_instr_slice import instr_slice_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [31:0] w;
        logic [7:0]  a;
        logic [31:0] e;
    } row_t;

    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          err_total, checked;
    row_t        rows[$];
    logic [7:0]  ra [7] = '{ADDR_INSTR, ADDR_ACC, ADDR_FLAGS, ADDR_BANK,
                            ADDR_PAGE, ADDR_PTR0, ADDR_PTR1};
    localparam logic [31:0] NOP = 32'h0;

    instr_slice #(.MEM_AW(12)) instr_slice_i (
        .CLOCK_I(clk), .RSTN_I(rst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready));

    // Free-running 125 MHz clock.
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Closing verdict, reached from the main flow and from any hang.
    task automatic report_and_stop;
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic hang;
        err_total++;
        report_and_stop;
    endtask

    task automatic chk(logic [31:0] g, logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Write cycle: address and data are offered together, each dropped
    // once taken, and bready stays up until the response is sampled.
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
                      output logic [1:0] r);
        bit aw_ok = 0;
        bit w_ok = 0;
        int i;
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (aw_ok && w_ok && bvalid === 1'h1) break;
            if (awready === 1'h1 && !aw_ok) begin
                aw_ok = 1;
                awvalid <= 1'h0;
            end
            if (wready === 1'h1 && !w_ok) begin
                w_ok = 1;
                wvalid <= 1'h0;
            end
        end
        if (i == 100) hang;
        r = bresp;
        bready <= 1'h0;
        @(posedge clk);
    endtask

    // Read cycle; the trailing edge keeps back-to-back calls apart.
    task automatic rd(logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        bit a_ok = 0;
        int i;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (a_ok && rvalid === 1'h1) break;
            if (arready === 1'h1 && !a_ok) begin
                a_ok = 1;
                arvalid <= 1'h0;
            end
        end
        if (i == 100) hang;
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rc(logic [7:0] a, logic [31:0] e);
        rd(a, got, rs);
        chk(got, e);
    endtask

    task automatic rst_chk;
        foreach (ra[n]) rc(ra[n], 32'h0);
    endtask

    // Word builders: direct-form and indirect-load instructions.
    function automatic logic [31:0] iw(op_code_t op, logic [6:0] f,
                                       logic d, logic [7:0] k);
        return {8'h00, k, 4'h0, d, f, op};
    endfunction

    function automatic logic [31:0] il(logic p, logic r, logic [1:0] m,
                                       logic [7:0] k);
        return {8'h00, k, m, r, p, 8'h00, OP_ILOAD};
    endfunction

    task automatic add(logic [31:0] w, logic [7:0] a, logic [31:0] e);
        rows.push_back('{w, a, e});
    endtask

    // Main sequence: reset, table of instructions, then awkward cases.
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        err_total = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rst_chk;
        wr(ADDR_MEMWIN, 32'h0, 4'hf, rs);
        add(iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h81), ADDR_ACC, 32'h81);
        add(iw(OP_ACC_STORE, 7'h05, 1'h0, 8'h00), ADDR_FLAGS, 32'h0);
        add(iw(OP_LSL, 7'h05, 1'h0, 8'h00), ADDR_ACC, 32'h02);
        add(NOP, ADDR_FLAGS, 32'h1);
        add(iw(OP_LSR, 7'h05, 1'h1, 8'h00), ADDR_ACC, 32'h02);
        add(iw(OP_FMOVE, 7'h05, 1'h0, 8'h00), ADDR_ACC, 32'h40);
        add(NOP, ADDR_FLAGS, 32'h1);
        add(iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h00), ADDR_FLAGS, 32'h1);
        add(iw(OP_ACC_STORE, 7'h06, 1'h0, 8'h00), ADDR_FLAGS, 32'h1);
        add(iw(OP_FMOVE, 7'h06, 1'h1, 8'h00), ADDR_FLAGS, 32'h3);
        add(iw(OP_LSL, 7'h05, 1'h1, 8'h00), ADDR_FLAGS, 32'h0);
        add(iw(OP_LSL, 7'h05, 1'h1, 8'h00), ADDR_FLAGS, 32'h3);
        add(iw(OP_BANK_LIT, 7'h00, 1'h0, 8'hff), ADDR_BANK, 32'h1f);
        add(iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h3c), ADDR_FLAGS, 32'h3);
        add(iw(OP_ACC_STORE, 7'h7f, 1'h0, 8'h00), ADDR_FLAGS, 32'h3);
        add(iw(OP_BANK_LIT, 7'h00, 1'h0, 8'h00), ADDR_FLAGS, 32'h3);
        add(iw(OP_PAGE_LIT, 7'h00, 1'h0, 8'hff), ADDR_PAGE, 32'h7f);
        add(NOP, ADDR_FLAGS, 32'h3);
        add(il(1'h0, 1'h0, MODE_PRE_DEC, 8'h00), ADDR_PTR0, 32'hffff);
        add(NOP, ADDR_ACC, 32'h3c);
        add(NOP, ADDR_FLAGS, 32'h1);
        add(il(1'h0, 1'h0, MODE_POST_INC, 8'h00), ADDR_PTR0, 32'h0);
        add(il(1'h1, 1'h0, MODE_POST_DEC, 8'h00), ADDR_PTR1, 32'hffff);
        add(NOP, ADDR_FLAGS, 32'h3);
        add(il(1'h1, 1'h0, MODE_PRE_INC, 8'h00), ADDR_PTR1, 32'h0);
        add(il(1'h0, 1'h1, 2'h0, 8'h3f), ADDR_ACC, 32'h3c);
        add(NOP, ADDR_PTR0, 32'h0);
        add(iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h5a), ADDR_ACC, 32'h5a);
        add(iw(OP_ACC_STORE, 7'h00, 1'h0, 8'h00), ADDR_MEMWIN, 32'h5a);
        add(iw(OP_ACC_STORE, 7'h1f, 1'h0, 8'h00), ADDR_FLAGS, 32'h1);
        add(iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h00), ADDR_ACC, 32'h0);
        add(iw(OP_FMOVE, 7'h01, 1'h0, 8'h00), ADDR_ACC, 32'h5a);
        add(iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h11), ADDR_ACC, 32'h11);
        add(il(1'h1, 1'h1, 2'h0, 8'h1f), ADDR_ACC, 32'h5a);
        foreach (rows[n]) begin
            wr(ADDR_INSTR, rows[n].w, 4'hf, rs);
            rc(rows[n].a, rows[n].e);
        end
        // Unmapped places answer with an error and change nothing.
        rd(8'h20, got, rs);
        chk(got, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(8'h24, 32'h0, 4'hf, rs);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        // Pointers are read-only; a cleared low strobe drops the write.
        wr(ADDR_PTR0, 32'h1234, 4'hf, rs);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        rc(ADDR_PTR0, 32'h0);
        wr(ADDR_INSTR, iw(OP_ACC_LIT, 7'h00, 1'h0, 8'h77), 4'he, rs);
        rc(ADDR_ACC, 32'h5a);
        // A second reset in mid-run clears the registers that were built up; memory keeps its contents.
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rst_chk;
        report_and_stop;
    end
endmodule
